//--- tmr_timer16.sv
/*
  Timer channel: one-shot pulse, PWM and free-running compare/capture modes
  on a 16-bit counter, counting on every core clock.
  Assumes synchronous register strobes and synchronous pin inputs.
*/
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/10ps
module tmr_timer16
  import tmr_pkg::*;
(
  input  wire logic                      core_clk,
  input  wire logic                      srst,
  input  wire logic [tmr_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [tmr_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [tmr_pkg::DATA_W-1:0] reg_rdata,
  input  wire logic                      ext_trigger,
  input  wire logic [1:0]                capture_in,
  output logic      [1:0]                timer_out,
  output logic      [1:0]                match_irq,
  output logic                           overflow_irq
);
  import tmr_pkg::*;

  logic [7:0]  control_reg0, next_control_reg0;
  logic [7:0]  control_reg1, next_control_reg1;
  logic [7:0]  option_reg0, next_option_reg0;
  logic [7:0]  io_control_two, next_io_control_two;
  logic [15:0] compare_reg0, next_compare_reg0;
  logic [15:0] compare_reg1, next_compare_reg1;
  logic [15:0] buf0, next_buf0;
  logic [15:0] buf1, next_buf1;
  logic        xfer_armed, next_xfer_armed;
  logic [15:0] count, next_count;
  logic        running, next_running;
  logic        pend_irq0, next_pend_irq0;
  logic        pend_ovf, next_pend_ovf;
  logic        ce_d, next_ce_d;
  logic        trig_d, next_trig_d;
  logic [1:0]  cap_d, next_cap_d;
  logic [1:0]  next_timer_out, next_match_irq;
  logic        next_overflow_irq;
  logic [15:0] next_reg_rdata;

  logic        ce;
  logic        ce_rise;
  tmr_mode_t   mode;
  logic        trig_edge;
  logic [1:0]  cap_edge;
  logic        wr_ccr0, wr_ccr1, soft_trig;

  assign ce        = control_reg0[CTL0_CE_BIT];
  assign ce_rise   = ce & ~ce_d;
  assign mode      = tmr_mode_t'(control_reg1[CTL1_MD_LSB +: 3]);
  assign wr_ccr0   = reg_wr && reg_addr == ADDR_CCR0;
  assign wr_ccr1   = reg_wr && reg_addr == ADDR_CCR1;
  assign soft_trig = reg_wr && reg_addr == ADDR_CTL1 && reg_wdata[CTL1_EST_BIT];

  function automatic logic edge_hit(input logic [1:0] sel, input logic prev,
                                    input logic cur);
    edge_hit = ((sel == EDGE_RISE || sel == EDGE_BOTH) && !prev && cur) ||
               ((sel == EDGE_FALL || sel == EDGE_BOTH) && prev && !cur);
  endfunction

  assign trig_edge = edge_hit(io_control_two[IOC2_ETS_LSB +: 2], trig_d, ext_trigger);

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_cap
      assign cap_edge[gi] = edge_hit(io_control_two[IOC2_EES_LSB +: 2], cap_d[gi],
                                     capture_in[gi]);
    end
  endgenerate

  // Register file
  always_comb begin
    next_control_reg0   = control_reg0;
    next_control_reg1   = control_reg1;
    next_option_reg0    = option_reg0;
    next_io_control_two = io_control_two;
    next_reg_rdata      = WORD_RESET;
    if (reg_wr) begin
      unique case (reg_addr)
        ADDR_CTL0: next_control_reg0 = reg_wdata[7:0];
        // Trigger bit is a strobe, never stored
        ADDR_CTL1: next_control_reg1 = reg_wdata[7:0] & ~(8'h01 << CTL1_EST_BIT);
        ADDR_OPT0: begin
          next_option_reg0 = reg_wdata[7:0];
          // Overflow bit can only be cleared by software
          next_option_reg0[OPT0_OVF_BIT] = option_reg0[OPT0_OVF_BIT] &
                                           reg_wdata[OPT0_OVF_BIT];
        end
        ADDR_IOC2: next_io_control_two = reg_wdata[7:0];
        default: ;
      endcase
    end
    // Hardware set wins over a simultaneous clear
    if (mode == TMR_MODE_FREERUN && pend_ovf) begin
      next_option_reg0[OPT0_OVF_BIT] = 1'b1;
    end
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_CTL0: next_reg_rdata = {8'h00, control_reg0};
        ADDR_CTL1: next_reg_rdata = {8'h00, control_reg1};
        ADDR_OPT0: next_reg_rdata = {8'h00, option_reg0};
        ADDR_IOC2: next_reg_rdata = {8'h00, io_control_two};
        ADDR_CCR0: next_reg_rdata = compare_reg0;
        ADDR_CCR1: next_reg_rdata = compare_reg1;
        ADDR_CNT:  next_reg_rdata = count;
        default:   next_reg_rdata = WORD_RESET;
      endcase
    end
  end

  // Counter, compare, capture and outputs
  always_comb begin
    next_compare_reg0 = wr_ccr0 ? reg_wdata : compare_reg0;
    next_compare_reg1 = wr_ccr1 ? reg_wdata : compare_reg1;
    next_buf0         = buf0;
    next_buf1         = buf1;
    next_xfer_armed   = xfer_armed | wr_ccr1;
    next_count        = count;
    next_running      = running;
    next_pend_irq0    = 1'b0;
    next_pend_ovf     = 1'b0;
    next_timer_out    = timer_out;
    next_match_irq    = 2'b00;
    next_overflow_irq = 1'b0;
    next_ce_d         = ce;
    next_trig_d       = ext_trigger;
    next_cap_d        = capture_in;

    if (!ce) begin
      next_count     = CNT_MAX;
      next_running   = 1'b0;
      next_timer_out = 2'b00;
    end else begin
      unique case (mode)
        TMR_MODE_ONESHOT: begin
          if (!running) begin
            // Retrigger while running is ignored
            if (trig_edge || soft_trig) begin
              next_running = 1'b1;
              next_count   = CNT_ZERO;
              next_timer_out[0] = 1'b1;
              if (compare_reg1 == CNT_ZERO && compare_reg1 <= compare_reg0) begin
                next_timer_out[1] = 1'b1;
                next_match_irq[1] = 1'b1;
              end
            end
          end else if (pend_irq0) begin
            next_match_irq[0] = 1'b1;
            next_timer_out    = 2'b00;
            next_running      = 1'b0;
            next_count        = CNT_MAX;
          end else begin
            // Live compare values; a passed value wraps through FFFFH
            next_count = count + CNT_ONE;
            if (next_count == compare_reg1 && compare_reg1 <= compare_reg0) begin
              next_timer_out[1] = 1'b1;
              next_match_irq[1] = 1'b1;
            end
            if (count == compare_reg0) begin
              // Pulse ends and count stops one clock after the period match
              next_pend_irq0    = 1'b1;
              next_timer_out[1] = 1'b0;
              next_count        = count;
            end
          end
        end
        TMR_MODE_PWM: begin
          if (ce_rise) begin
            next_count = CNT_ZERO;
            next_timer_out = 2'b00;
            next_timer_out[1] = compare_reg1 != CNT_ZERO;
            next_buf0 = compare_reg0;
            next_buf1 = compare_reg1;
            next_xfer_armed = 1'b0;
          end else if (count == buf0) begin
            next_count = CNT_ZERO;
            next_match_irq[0] = 1'b1;
            next_timer_out[0] = ~timer_out[0];
            if (xfer_armed) begin
              next_buf0 = compare_reg0;
              next_buf1 = compare_reg1;
              next_xfer_armed = wr_ccr1;
            end
            // Zero duty stays low all period
            next_timer_out[1] = next_buf1 != CNT_ZERO;
          end else begin
            next_count = count + CNT_ONE;
          end
          if (!ce_rise && next_count == buf1) begin
            next_match_irq[1] = 1'b1;
            next_timer_out[1] = 1'b0;
          end
        end
        TMR_MODE_FREERUN: begin
          if (ce_rise) begin
            next_count = CNT_ZERO;
            next_timer_out = ~timer_out;
          end else begin
            next_count = count + CNT_ONE;
            if (count == CNT_MAX) begin
              next_overflow_irq = 1'b1;
              next_pend_ovf     = 1'b1;
            end
          end
          for (int m = 0; m < 2; m++) begin
            if (option_reg0[OPT0_CCS0_BIT + m]) begin
              if (cap_edge[m]) begin
                next_match_irq[m] = 1'b1;
                if (m == 0) next_compare_reg0 = count;
                else next_compare_reg1 = count;
              end
            end else if (!ce_rise && count == (m == 0 ? compare_reg0 : compare_reg1)) begin
              // Match on the live register value
              next_match_irq[m] = 1'b1;
              next_timer_out[m] = ~timer_out[m];
            end
          end
        end
        default: begin
          next_count = CNT_MAX;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      control_reg0   <= BYTE_RESET;
      control_reg1   <= BYTE_RESET;
      option_reg0    <= BYTE_RESET;
      io_control_two <= BYTE_RESET;
      reg_rdata      <= WORD_RESET;
      compare_reg0   <= WORD_RESET;
      compare_reg1   <= WORD_RESET;
      buf0           <= WORD_RESET;
      buf1           <= WORD_RESET;
      xfer_armed     <= 1'b0;
      count          <= CNT_MAX;
      running        <= 1'b0;
      pend_irq0      <= 1'b0;
      pend_ovf       <= 1'b0;
      ce_d           <= 1'b0;
      trig_d         <= 1'b0;
      cap_d          <= 2'b00;
      timer_out      <= 2'b00;
      match_irq      <= 2'b00;
      overflow_irq   <= 1'b0;
    end else begin
      control_reg0   <= next_control_reg0;
      control_reg1   <= next_control_reg1;
      option_reg0    <= next_option_reg0;
      io_control_two <= next_io_control_two;
      reg_rdata      <= next_reg_rdata;
      compare_reg0   <= next_compare_reg0;
      compare_reg1   <= next_compare_reg1;
      buf0           <= next_buf0;
      buf1           <= next_buf1;
      xfer_armed     <= next_xfer_armed;
      count          <= next_count;
      running        <= next_running;
      pend_irq0      <= next_pend_irq0;
      pend_ovf       <= next_pend_ovf;
      ce_d           <= next_ce_d;
      trig_d         <= next_trig_d;
      cap_d          <= next_cap_d;
      timer_out      <= next_timer_out;
      match_irq      <= next_match_irq;
      overflow_irq   <= next_overflow_irq;
    end
  end
endmodule

//--- tmr_pkg.sv
/*
  Package for the 16-bit timer channel: register indices, field positions,
  mode encodings and reset values.
  Assumes a simple strobe register port with 16-bit data.
*/
package tmr_pkg;
  localparam int          ADDR_W        = 4;
  localparam int          DATA_W        = 16;
  localparam logic [3:0]  ADDR_CTL0     = 4'h0;
  localparam logic [3:0]  ADDR_CTL1     = 4'h1;
  localparam logic [3:0]  ADDR_OPT0     = 4'h2;
  localparam logic [3:0]  ADDR_IOC2     = 4'h3;
  localparam logic [3:0]  ADDR_CCR0     = 4'h4;
  localparam logic [3:0]  ADDR_CCR1     = 4'h5;
  localparam logic [3:0]  ADDR_CNT      = 4'h6;
  localparam int          CTL0_CE_BIT   = 7;
  localparam int          CTL1_EST_BIT  = 6;
  localparam int          CTL1_MD_LSB   = 0;
  localparam int          OPT0_OVF_BIT  = 0;
  localparam int          OPT0_CCS0_BIT = 4;
  localparam int          OPT0_CCS1_BIT = 5;
  localparam int          IOC2_ETS_LSB  = 0;
  localparam int          IOC2_EES_LSB  = 2;
  localparam logic [15:0] CNT_MAX       = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO      = 16'h0000;
  localparam logic [15:0] CNT_ONE       = 16'h0001;
  localparam logic [7:0]  BYTE_RESET    = 8'h00;
  localparam logic [15:0] WORD_RESET    = 16'h0000;

  typedef enum logic [2:0] {
    TMR_MODE_ONESHOT = 3'b011,
    TMR_MODE_PWM     = 3'b100,
    TMR_MODE_FREERUN = 3'b101
  } tmr_mode_t;

  // Edge select codes for trigger and capture inputs
  localparam logic [1:0]  EDGE_NONE     = 2'b00;
  localparam logic [1:0]  EDGE_RISE     = 2'b01;
  localparam logic [1:0]  EDGE_FALL     = 2'b10;
  localparam logic [1:0]  EDGE_BOTH     = 2'b11;
endpackage

//--- tmr_timer16_properties.sv
/* Port checker for the timer channel: output and interrupt timing per mode.
   Assumes it is bound to tmr_timer16 with one core_clk domain. */
`timescale 1ns/10ps
module tmr_chk
  import tmr_pkg::*;
(
  input wire logic                       core_clk,
  input wire logic                       srst,
  input wire logic [tmr_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [tmr_pkg::DATA_W-1:0] reg_wdata,
  input wire logic                       reg_wr,
  input wire logic                       reg_rd,
  input wire logic [tmr_pkg::DATA_W-1:0] reg_rdata,
  input wire logic                       ext_trigger,
  input wire logic [1:0]                 capture_in,
  input wire logic [1:0]                 timer_out,
  input wire logic [1:0]                 match_irq,
  input wire logic                       overflow_irq
);
  logic [2:0] mode;
  logic [2:0] next_mode;
  logic       ce;
  logic       next_ce;
  logic       cs0;
  logic       next_cs0;
  // Shadow of what software wrote; the checker cannot see inside
  always_comb begin
    next_mode = mode;
    next_ce   = ce;
    next_cs0  = cs0;
    if (reg_wr && reg_addr == ADDR_CTL1) next_mode = reg_wdata[2:0];
    if (reg_wr && reg_addr == ADDR_CTL0) next_ce = reg_wdata[CTL0_CE_BIT];
    if (reg_wr && reg_addr == ADDR_OPT0) next_cs0 = reg_wdata[OPT0_CCS0_BIT];
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      mode <= 3'h0;
      ce   <= 1'b0;
      cs0  <= 1'b0;
    end else begin
      mode <= next_mode;
      ce   <= next_ce;
      cs0  <= next_cs0;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside read slot");
  a_irq0_single: assert property (match_irq[0] |=> !match_irq[0])
    else $error("match irq 0 longer than one cycle");
  a_ovf_single: assert property (overflow_irq |=> !overflow_irq)
    else $error("overflow irq longer than one cycle");
  a_os_irq1_align: assert property ((ce && mode == TMR_MODE_ONESHOT && $rose(timer_out[1]))
    |-> match_irq[1]) else $error("one-shot irq1 not with output rise");
  a_os_out1_inside: assert property ((mode == TMR_MODE_ONESHOT && timer_out[1]) |-> timer_out[0])
    else $error("one-shot pulse outside counting");
  a_pwm_irq1_align: assert property ((ce && mode == TMR_MODE_PWM && $fell(timer_out[1]))
    |-> match_irq[1]) else $error("pwm irq1 not with output fall");
  a_free_cmp_toggle: assert property ((ce && mode == TMR_MODE_FREERUN && !cs0 && match_irq[0])
    |-> timer_out[0] != $past(timer_out[0])) else $error("compare match without toggle");
  a_free_start_inv: assert property ((!ce && mode == TMR_MODE_FREERUN && reg_wr
    && reg_addr == ADDR_CTL0 && reg_wdata[CTL0_CE_BIT]) |-> ##[1:3] timer_out == 2'b11)
    else $error("free-run start did not invert outputs");
  c_pwm_period: cover property (ce && mode == TMR_MODE_PWM && match_irq[0]);
  c_os_pulse: cover property (mode == TMR_MODE_ONESHOT && $rose(timer_out[1]));
  c_overflow: cover property (overflow_irq);
endmodule
bind tmr_timer16 tmr_chk i_chk (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .ext_trigger(ext_trigger), .capture_in(capture_in), .timer_out(timer_out),
  .match_irq(match_irq), .overflow_irq(overflow_irq));

//--- tmr_pins_model.sv
/* Pulse sources on the trigger and capture pins.
   Assumes requests are one-cycle strobes; each gives a 4-cycle high pulse. */
`timescale 1ns/10ps
module tmr_pins_model (
  input  wire logic       core_clk,
  input  wire logic       srst,
  input  wire logic [2:0] pin_req,
  output logic            ext_trigger,
  output logic [1:0]      capture_in
);
  logic [2:0] len      [3];
  logic [2:0] next_len [3];
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      next_len[i] = pin_req[i] ? 3'h4 : (len[i] != 3'h0 ? len[i] - 3'h1 : 3'h0);
    end
  end
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < 3; i++) begin
      len[i] <= srst ? 3'h0 : next_len[i];
    end
  end
  // Idle level is low, as a driven source would rest
  assign ext_trigger = len[0] != 3'h0;
  assign capture_in  = {len[2] != 3'h0, len[1] != 3'h0};
endmodule

//--- tb.sv
/* Self-checking bench for the timer channel: registers, one-shot, PWM, free-run.
   Assumes tmr_timer16, tmr_pins_model and the bound checker. */
`timescale 1ns/10ps
module tb;
  import tmr_pkg::*;
  logic        core_clk, srst, reg_wr, reg_rd, ext_trigger, overflow_irq;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rv, cv;
  logic [1:0]  capture_in, timer_out, match_irq;
  logic [2:0]  pin_req;
  int          err_total, cmp_count, hi1, ni0, ni1, tog0, f0, f1;
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
  tmr_timer16 i_dut (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ext_trigger(ext_trigger), .capture_in(capture_in), .timer_out(timer_out),
    .match_irq(match_irq), .overflow_irq(overflow_irq));
  tmr_pins_model i_pins (.core_clk(core_clk), .srst(srst), .pin_req(pin_req),
    .ext_trigger(ext_trigger), .capture_in(capture_in));
  task automatic tally_and_finish();
    if (err_total == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [15:0] e);
    rd(a, rv);
    `CHK(rv, e)
  endtask
  task automatic pulse(input int i);
    @(posedge core_clk);
    pin_req[i] <= 1'b1;
    @(posedge core_clk);
    pin_req[i] <= 1'b0;
  endtask
  // Counts output activity over a fixed window of cycles
  task automatic observe(input int n);
    logic p0;
    hi1 = 0; ni0 = 0; ni1 = 0; tog0 = 0; f0 = -1; f1 = -1;
    p0 = timer_out[0];
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      #1;
      if (timer_out[1] === 1'b1) hi1++;
      if (match_irq[0] === 1'b1) ni0++;
      if (match_irq[1] === 1'b1) ni1++;
      if (timer_out[0] !== p0) tog0++;
      p0 = timer_out[0];
      if (timer_out[0] === 1'b1 && f0 < 0) f0 = i;
      if (timer_out[1] === 1'b1 && f1 < 0) f1 = i;
    end
  endtask
  task automatic wait_sig(input int w, input int lim);
    int k;
    for (k = 0; k < lim; k++) begin
      @(posedge core_clk);
      #1;
      if ((w == 2 ? overflow_irq : match_irq[w]) === 1'b1) break;
    end
    if (k == lim) begin
      err_total++;
      tally_and_finish();
    end
  endtask
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin
    srst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 4'h0; reg_wdata = 16'h0000;
    pin_req = 3'h0; err_total = 0; cmp_count = 0;
    repeat (20) @(posedge core_clk);
    srst <= 1'b0;
    for (int a = 0; a < 8; a++) rdc(a[3:0], a == 6 ? 16'hFFFF : 16'h0000);
    wr(ADDR_IOC2, 16'h0005);
    wr(ADDR_CCR0, 16'h0004);
    wr(ADDR_CCR1, 16'h0002);
    wr(ADDR_CTL1, 16'h0003);
    wr(ADDR_CTL0, 16'h0080);
    pulse(0);
    observe(20);
    `CHK(hi1, 3)
    `CHK(f1 - f0, 2)
    `CHK(ni0, 1)
    `CHK(ni1, 1)
    rdc(ADDR_CTL1, 16'h0003);
    rdc(ADDR_CNT, 16'hFFFF);
    // Soft trigger, then a pin edge mid-pulse that must be ignored
    wr(ADDR_CTL1, 16'h0043);
    pulse(0);
    observe(20);
    `CHK(hi1, 2)
    wr(ADDR_CCR1, 16'h0005);
    wr(ADDR_CTL1, 16'h0043);
    observe(20);
    `CHK(hi1, 0)
    wr(ADDR_CTL0, 16'h0000);
    wr(ADDR_CCR0, 16'h0009);
    wr(ADDR_CCR1, 16'h0003);
    wr(ADDR_CTL1, 16'h0004);
    wr(ADDR_CTL0, 16'h0080);
    wait_sig(0, 40);
    observe(50);
    `CHK({hi1, ni0, ni1, tog0}, {32'd15, 32'd5, 32'd5, 32'd5})
    rd(ADDR_CNT, rv);
    `CHK(rv < 16'h000A, 1'b1)
    // Period write alone must not reach the buffer
    wr(ADDR_CCR0, 16'h0004);
    observe(50);
    `CHK(ni0, 5)
    wr(ADDR_CCR1, 16'h0002);
    wait_sig(0, 40);
    for (int j = 0; j < 3; j++) begin
      wr(ADDR_CCR1, j == 0 ? 16'h0002 : (j == 1 ? 16'h0000 : 16'h0005));
      wait_sig(0, 40);
      wait_sig(0, 40);
      observe(50);
      `CHK(ni0, 10)
      `CHK(hi1, j == 0 ? 20 : (j == 1 ? 0 : 50))
      if (j == 1) `CHK(ni1, 10)
    end
    wr(ADDR_CTL0, 16'h0000);
    wr(ADDR_OPT0, 16'h0020);
    wr(ADDR_CCR0, 16'h0010);
    wr(ADDR_CTL1, 16'h0005);
    wr(ADDR_CTL0, 16'h0080);
    wait_sig(0, 40);
    `CHK(timer_out, 2'b10)
    wr(ADDR_CCR0, 16'h0100);
    wait_sig(0, 300);
    rd(ADDR_CNT, rv);
    `CHK(rv >= 16'h0100 && rv < 16'h0110, 1'b1)
    pulse(2);
    wait_sig(1, 20);
    rd(ADDR_CCR1, cv);
    rd(ADDR_CNT, rv);
    `CHK(rv - cv < 16'h0010 && cv > 16'h0100, 1'b1)
    wait_sig(2, 70000);
    rd(ADDR_CNT, rv);
    `CHK(rv < 16'h0010, 1'b1)
    rdc(ADDR_OPT0, 16'h0021);
    wr(ADDR_OPT0, 16'h0020);
    rdc(ADDR_OPT0, 16'h0020);
    tally_and_finish();
  end
endmodule
